//--- shared/crc_host_cfg.svh
// Purpose: constants for the host-side check generator
// Assumes: bytes enter least significant bit first
// Notes:   polynomials given as reflected tap masks
`ifndef CRC_HOST_CFG_SVH
`define CRC_HOST_CFG_SVH
// x^8 + x^5 + x^4 + 1, reflected
`define CRC8_POLY     8'h8C
// x^16 + x^15 + x^2 + 1, reflected
`define CRC16_POLY    16'hA001
`define CRC8_INIT     8'h00
`define CRC16_INIT    16'h0000
`define ID_BYTES      4'h7
`define PAGE_BYTES    8
`endif

//--- shared/crc_host_pkg.sv
// Purpose: types for the host-side check generator
// Assumes: none
// Notes:   operation codes chosen locally
package crc_host_pkg;
  typedef enum logic [2:0] {
    OP_CLEAR   = 3'b000,
    OP_SHIFT   = 3'b001,
    OP_LOADADR = 3'b010,
    OP_IDCLEAR = 3'b011,
    OP_IDSHIFT = 3'b100
  } crc_op_t;

  typedef struct packed {
    crc_op_t     op;
    logic [15:0] data;
  } crc_cmd_t;

  typedef struct packed {
    logic        idOk;
    logic        idDone;
    logic        memOk;
    logic [15:0] memCrc;
    logic [7:0]  idCrc;
  } crc_stat_t;
endpackage

//--- core/eprom_crc_host.sv
// Purpose: host-side recomputation of both link checks
// Assumes: sequencer issues clear/shift/load per transaction shape
// Notes:   one byte per cycle; comparison is the host's verdict
`timescale 1ns/100ps
`include "crc_host_cfg.svh"
module eprom_crc_host (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  // Command from sequencer
  input  wire logic                  cmdValid,
  input  wire crc_host_pkg::crc_cmd_t cmd,
  // Received check values
  input  wire logic                  cmpValid,
  input  wire logic [15:0]           rxMemCrc,
  input  wire logic [7:0]            rxIdCrc,
  // Results
  output crc_host_pkg::crc_stat_t    stat,
  output logic                       cmpDone,
  output logic                       progAllow
);
  import crc_host_pkg::*;

  // ==========================================================
  // Byte-wide generators
  function automatic logic [15:0] crc16Byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      // Lsb first, reflected taps
      if (r[0] ^ d[i]) r = (r >> 1) ^ `CRC16_POLY;
      else r = r >> 1;
    end
    return r;
  endfunction

  function automatic logic [7:0] crc8Byte(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      // Lsb first
      if (r[0] ^ d[i]) r = (r >> 1) ^ `CRC8_POLY;
      else r = r >> 1;
    end
    return r;
  endfunction

  // ==========================================================
  // State
  logic [15:0] memReg,  memNext;
  logic [7:0]  idReg,   idNext;
  logic [3:0]  idCntReg, idCntNext;
  logic        idOkReg, idOkNext;
  logic        memOkReg, memOkNext;
  logic        doneReg, doneNext;
  logic        allowReg, allowNext;

  always_comb begin
    memNext   = memReg;
    idNext    = idReg;
    idCntNext = idCntReg;
    idOkNext  = idOkReg;
    memOkNext = memOkReg;
    doneNext  = 1'b0;
    allowNext = allowReg;
    if (cmdValid) begin
      case (cmd.op)
        OP_CLEAR: begin
          // Clear before each command, page or redirection
          memNext   = `CRC16_INIT;
          allowNext = 1'b0;
        end
        OP_SHIFT: begin
          memNext   = crc16Byte(memReg, cmd.data[7:0]);
          allowNext = 1'b0;
        end
        OP_LOADADR: begin
          // Incremented address loaded, not shifted
          memNext   = cmd.data;
          allowNext = 1'b0;
        end
        OP_IDCLEAR: begin
          idNext    = `CRC8_INIT;
          idCntNext = 4'h0;
        end
        OP_IDSHIFT: begin
          // Only the first 56 bits are covered
          // Eighth byte is the stored check; it arrives on rxIdCrc instead
          if (idCntReg < `ID_BYTES) begin
            idNext    = crc8Byte(idReg, cmd.data[7:0]);
            idCntNext = idCntReg + 4'h1;
          end
        end
        // Unused codes leave both generators alone
        default: begin
          memNext = memReg;
        end
      endcase
    end
    // Verdict overrides a withdrawal from a command in the same cycle
    if (cmpValid) begin
      // Device returns inverted 16-bit, true 8-bit
      memOkNext = (~rxMemCrc == memReg);
      idOkNext  = (idCntReg == `ID_BYTES) && (rxIdCrc == idReg);
      doneNext  = 1'b1;
      // Programming allowed only on a matching
      allowNext = (~rxMemCrc == memReg);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      memReg   <= `CRC16_INIT;
      idReg    <= `CRC8_INIT;
      idCntReg <= 4'h0;
      idOkReg  <= 1'b0;
      memOkReg <= 1'b0;
      doneReg  <= 1'b0;
      allowReg <= 1'b0;
    end else begin
      memReg   <= memNext;
      idReg    <= idNext;
      idCntReg <= idCntNext;
      idOkReg  <= idOkNext;
      memOkReg <= memOkNext;
      doneReg  <= doneNext;
      allowReg <= allowNext;
    end
  end

  // ==========================================================
  // Outputs
  // Running values stay visible for the sequencer's own log
  always_comb begin
    stat.idOk   = idOkReg;
    stat.idDone = (idCntReg == `ID_BYTES);
    stat.memOk  = memOkReg;
    stat.memCrc = memReg;
    stat.idCrc  = idReg;
  end
  assign cmpDone   = doneReg;
  assign progAllow = allowReg;

  // ==========================================================
  // Checks
  clear_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmdValid && cmd.op == OP_CLEAR |=> memReg == 16'h0000)
    else $error("generator not cleared");
  load_addr_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmdValid && cmd.op == OP_LOADADR |=> memReg == $past(cmd.data))
    else $error("address not loaded directly");
  prog_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    progAllow |-> memOkReg)
    else $error("programming allowed on bad check");
  inv_compare_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmpValid && !cmdValid |=> memOkReg == (~$past(rxMemCrc) == memReg))
    else $error("inverted compare wrong");
  id_count_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    idCntReg <= `ID_BYTES)
    else $error("identity byte count overrun");
  done_pulse_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmpValid |=> cmpDone)
    else $error("compare not reported");
  shift_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmdValid && cmd.op == OP_SHIFT && memReg == 16'h0000 && cmd.data[7:0] == 8'h01
    |=> memReg == 16'hC0C1)
    else $error("16-bit polynomial wrong");
  id_poly_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmdValid && cmd.op == OP_IDSHIFT && idCntReg < 4'h7 && idReg == 8'h00
    && cmd.data[7:0] == 8'h01 |=> idReg == 8'h5E)
    else $error("8-bit polynomial wrong");

  // A memory-generator command (clear, shift, address load) with no compare in the same cycle withdraws an earlier go-ahead
  allow_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmdValid && !cmpValid && (cmd.op == OP_CLEAR || cmd.op == OP_SHIFT
    || cmd.op == OP_LOADADR) |=> !progAllow)
    else $error("programming left allowed after new data");
  allow_verdict_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmpValid |=> progAllow == memOkReg)
    else $error("programming permission differs from verdict");
  id_refuse_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmdValid && cmd.op == OP_IDSHIFT && idCntReg == `ID_BYTES |=> $stable(idReg))
    else $error("stored check byte folded into identity check");
  id_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmdValid && cmd.op == OP_IDCLEAR |=> idReg == 8'h00 && !stat.idDone)
    else $error("identity generator not cleared");
  id_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmpValid && idCntReg != `ID_BYTES |=> !stat.idOk)
    else $error("identity accepted before 56 bits");
  done_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !cmpValid |=> !cmpDone)
    else $error("compare reported without request");
  mem_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !cmdValid |=> $stable(memReg))
    else $error("generator moved without a command");
  shift_msb_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmdValid && cmd.op == OP_SHIFT && memReg == 16'h0000 && cmd.data[7:0] == 8'h80
    |=> memReg == 16'hA001)
    else $error("byte not shifted least significant bit first");
endmodule

//--- test/eprom_dev_model.sv
// Purpose: behavioural device side, computes the checks it sends
// Assumes: bytes enter least significant bit first
// Notes:   no line timing, values only
`timescale 1ns/100ps
module eprom_dev_model;
  // ==========
  // Generators
  localparam logic [55:0] ID_LOW = 56'h005A_1C3E_772D_3C; // Arbitrary family and serial
  logic [15:0] memCrc = 16'h0000;
  function automatic logic [15:0] c16(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) c = ((c[0] ^ b[i]) ? 16'hA001 : 16'h0000) ^ (c >> 1);
    return c;
  endfunction
  function automatic logic [7:0] c8(input logic [7:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) c = ((c[0] ^ b[i]) ? 8'h8C : 8'h00) ^ (c >> 1);
    return c;
  endfunction
  function automatic logic [7:0] idByte(input int n);
    logic [7:0] c;
    c = 8'h00;
    if (n < 7) return ID_LOW[8*n +: 8];
    for (int k = 0; k < 7; k++) c = c8(c, ID_LOW[8*k +: 8]); // Top byte
    return c; // Sent true
  endfunction
  // ==========
  // Transaction steps
  task automatic clr(); memCrc = 16'h0000; endtask
  task automatic sh(input logic [7:0] b); memCrc = c16(memCrc, b); endtask
  task automatic ld(input logic [15:0] a); memCrc = a; endtask // Unshifted
  function automatic logic [15:0] tx(); return ~memCrc; endfunction // Never blocks
endmodule

//--- test/testbench.sv
// Purpose: scenario bench for the host check generator
// Assumes: one command per cycle, results one edge later
// Notes:   device values come from the partner model
`timescale 1ns/100ps
module testbench;
  import crc_host_pkg::*;
  logic clk_sys = 1'b0, rstn = 1'b0, cmdValid = 1'b0, cmpValid = 1'b0;
  crc_cmd_t cmd = '0;
  logic [15:0] rxMemCrc = 16'h0000;
  logic [7:0] rxIdCrc = 8'h00;
  crc_stat_t stat;
  logic cmpDone, progAllow;
  int err_total = 0, cmp_count = 0;
  eprom_dev_model dev();
  eprom_crc_host dut(.clk_sys(clk_sys), .rstn(rstn), .cmdValid(cmdValid), .cmd(cmd),
    .cmpValid(cmpValid), .rxMemCrc(rxMemCrc), .rxIdCrc(rxIdCrc), .stat(stat),
    .cmpDone(cmpDone), .progAllow(progAllow));
  initial forever #12.5 clk_sys = ~clk_sys;
  // ==========
  // Shared tasks
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic op(input crc_op_t o, input logic [15:0] d);
    @(posedge clk_sys);
    cmdValid <= 1'b1;
    cmd <= '{op: o, data: d};
  endtask
  task automatic stop();
    @(posedge clk_sys);
    cmdValid <= 1'b0;
    #1;
  endtask
  task automatic cmp(input logic [15:0] m, input logic [7:0] i);
    @(posedge clk_sys);
    cmpValid <= 1'b1;
    rxMemCrc <= m;
    rxIdCrc <= i;
    @(posedge clk_sys);
    cmpValid <= 1'b0;
    #1;
    chk("cmpDone", 16'h0001, {15'h0, cmpDone});
  endtask
  task automatic sh(input logic [7:0] b); op(OP_SHIFT, {8'h00, b}); dev.sh(b); endtask
  task automatic clr(); op(OP_CLEAR, 16'h0000); dev.clr(); endtask
  task automatic check_mem(input string s);
    stop();
    chk(s, dev.memCrc, stat.memCrc);
    cmp(dev.tx(), 8'h00);
    chk("memOk", 16'h0001, {15'h0, stat.memOk});
  endtask
  // ==========
  // Scenarios
  task automatic t_id();
    op(OP_IDCLEAR, 16'h0000);
    op(OP_IDSHIFT, 16'h0001);
    stop();
    chk("idVec", 16'h005E, {8'h00, stat.idCrc});
    op(OP_IDCLEAR, 16'h0000);
    for (int k = 0; k < 8; k++) op(OP_IDSHIFT, {8'h00, dev.idByte(k)}); // Eighth refused
    stop();
    chk("idCrc", {8'h00, dev.idByte(7)}, {8'h00, stat.idCrc});
    chk("idDone", 16'h0001, {15'h0, stat.idDone});
    cmp(dev.tx(), dev.idByte(7));
    chk("idOk", 16'h0001, {15'h0, stat.idOk});
    $display("test id done");
  endtask
  task automatic t_read();
    clr();
    sh(8'hF0);
    sh(8'h1D);
    sh(8'h00);
    sh(8'hFF);
    sh(8'h00);
    sh(8'h81);
    stop();
    chk("memCrc", dev.memCrc, stat.memCrc);
    cmp(dev.tx(), 8'h00);
    chk("memOk", 16'h0001, {15'h0, stat.memOk});
    sh(8'h33);
    stop();
    chk("progAllow", 16'h0000, {15'h0, progAllow});
    $display("test read done");
  endtask
  task automatic t_write();
    clr();
    sh(8'h0F);
    sh(8'h20);
    sh(8'h00);
    sh(8'hC4);
    stop();
    cmp(dev.tx(), 8'h00);
    chk("progAllow", 16'h0001, {15'h0, progAllow});
    op(OP_LOADADR, 16'h0021);
    dev.ld(16'h0021);
    sh(8'h5E);
    stop();
    chk("memCrc", dev.memCrc, stat.memCrc);
    cmp(~dev.tx(), 8'h00);
    chk("badOk", 16'h0000, {14'h0, stat.memOk, progAllow});
    $display("test write done");
  endtask
  task automatic t_reset();
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("rstMem", 16'h0000, stat.memCrc);
    chk("rstId", 16'h0000, {8'h00, stat.idCrc});
    chk("rstStat", 16'h0000, {13'h0, stat.idOk, stat.idDone, stat.memOk});
    chk("rstOut", 16'h0000, {14'h0, cmpDone, progAllow});
    $display("test reset done");
  endtask
  task automatic t_pages();
    // Status read entered at byte 5, then a whole page
    clr();
    sh(8'hAA);
    sh(8'h05);
    sh(8'h00);
    for (int k = 5; k < 8; k++) sh(8'(k));
    check_mem("statFirst");
    clr();
    sh(8'h80);
    stop();
    chk("vecMsb", 16'hA001, stat.memCrc);
    for (int k = 1; k < 8; k++) sh(8'(k));
    check_mem("statNext");
    // Extended read: two redirection bytes, then one data page
    clr();
    sh(8'hA5);
    sh(8'h10);
    sh(8'h00);
    sh(8'hFF);
    check_mem("extFirst");
    clr();
    sh(8'hFE);
    check_mem("extNext");
    clr();
    sh(8'h01);
    stop();
    chk("vecOne", 16'hC0C1, stat.memCrc);
    for (int k = 1; k < 8; k++) sh(8'(k));
    check_mem("extPage");
    $display("test pages done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    t_id();
    t_read();
    t_write();
    t_reset();
    t_pages();
    end_of_test();
  end
  initial begin
    repeat (2000) @(posedge clk_sys);
    err_total++;
    end_of_test();
  end
endmodule
